/* File: cipc_top.sv */
// The register offsets and the Wishbone register port are this design's own decisions.
`timescale 1ns/1ps
module cipc_top (
    // system
    input  wire logic                      clock,
    input  wire logic                      reset,
    // wishbone slave
    input  wire logic [cipc_pkg::ADR_W-1:0] wb_adr_i,
    input  wire logic [31:0]               wb_dat_i,
    output logic      [31:0]               wb_dat_o,
    input  wire logic                      wb_we_i,
    input  wire logic [3:0]                wb_sel_i,
    input  wire logic                      wb_cyc_i,
    input  wire logic                      wb_stb_i,
    output logic                           wb_ack_o,
    // internal fault sources
    input  wire logic                      illegal_opcode,
    input  wire logic                      power_fail_pin,
    input  wire logic                      memory_error_flag,
    input  wire logic                      prot_addr_violation,
    input  wire logic                      prot_instr_violation,
    // external requests
    input  wire logic                      expanded_req,
    input  wire logic [15:0]               expanded_vector,
    input  wire logic                      dma_channel_req,
    input  wire logic                      io_bus_req,
    // instruction boundary
    input  wire logic                      instr_done,
    input  wire logic                      direct_output_instr,
    input  wire logic                      direct_input_instr,
    input  wire logic                      exempt_status_instr_a,
    input  wire logic                      exempt_status_instr_b,
    input  wire logic                      rr_to_status_instr,
    // auxiliary processor port
    input  wire logic                      aux_processor_instr,
    input  wire logic                      aux_present,
    input  wire logic                      aux_done,
    input  wire logic                      aux_addr_violation,
    output logic                           aux_abort,
    output logic                           aux_revoke,
    output logic                           exec_hold,
    // vector out
    output logic                           vector_valid,
    output logic      [15:0]               vector_addr,
    output logic      [15:0]               status_word,
    output logic                           irq
);
    import cipc_pkg::*;
    // ==================================================
    // state
    logic [15:0]     sw_ff;        // machine status word
    logic [2:0]      pwr_sync_ff;  // power fail synchroniser
    logic            pwr_lvl_ff;   // agreed power fail level
    logic            pend_ill_ff;  // pending illegal opcode
    logic            pend_pwr_ff;  // pending power failure
    logic            pend_par_ff;  // pending parity error
    logic            pend_av_ff;   // pending address violation
    logic            pend_iv_ff;   // pending instr violation
    cipc_aux_t       aux_ff;       // aux port state
    logic            vld_ff;       // vector strobe
    logic [15:0]     vec_ff;       // vector address
    logic            rvk_ff;       // revoke strobe
    logic [EV_W-1:0] ists_ff;      // irq status
    logic [EV_W-1:0] imask_ff;     // irq mask
    logic            ack_ff;       // bus answer
    logic [31:0]     rdat_ff;      // bus read data
    // ==================================================
    // combinational terms
    logic            pwr_rise;     // power fail onset
    logic            int_pend;     // any internal pending
    logic            check;        // boundary check allowed
    logic            take_int, take_exp, take_dma, take_io;
    logic            aux_ill;      // aux instr w/o device
    logic            revoke;       // immediate aux revoke
    logic            wr, rd;       // bus strobes
    logic [15:0]     sw_wmask;     // status byte enables
    logic [EV_W-1:0] ev;           // irq events
    logic [15:0]     nxt_sw;       // next status word
    // power fail counts once stages two and three agree
    assign pwr_rise = pwr_sync_ff[1] & pwr_sync_ff[2] & ~pwr_lvl_ff;
    assign int_pend = pend_ill_ff | pend_pwr_ff | pend_par_ff
                    | pend_av_ff | pend_iv_ff;
    // no check after direct i/o, exempt status, rr to status
    assign check = instr_done & ~direct_output_instr
                 & ~direct_input_instr & ~exempt_status_instr_a
                 & ~exempt_status_instr_b
                 & ~rr_to_status_instr;
    // strict priority, one winner only
    assign take_int = check & int_pend;
    assign take_exp = check & ~int_pend & expanded_req
                    & sw_ff[SB_EXP_EN];
    assign take_dma = check & ~int_pend
                    & ~(expanded_req & sw_ff[SB_EXP_EN])
                    & dma_channel_req & sw_ff[SB_DMA_EN];
    assign take_io  = check & ~int_pend
                    & ~(expanded_req & sw_ff[SB_EXP_EN])
                    & ~(dma_channel_req & sw_ff[SB_DMA_EN])
                    & io_bus_req & sw_ff[SB_IO_EN];
    assign aux_ill  = aux_processor_instr & ~aux_present;
    assign revoke   = (aux_ff == AUX_BUSY) & aux_addr_violation
                    & sw_ff[SB_PROT_EN];
    assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ~ack_ff;
    assign rd = wb_cyc_i & wb_stb_i & ~wb_we_i & ~ack_ff;
    assign sw_wmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    assign ev = {rvk_ff, take_io, take_dma, take_exp, take_int};
    // ==================================================
    // power fail pin synchroniser, whole block on clock
    always_ff @(posedge clock) begin
        if (reset) begin
            pwr_sync_ff <= 3'h0;
            pwr_lvl_ff  <= 1'b0;
        end else begin
            pwr_sync_ff <= {pwr_sync_ff[1:0], power_fail_pin};
            if (pwr_sync_ff[1] == pwr_sync_ff[2]) begin
                pwr_lvl_ff <= pwr_sync_ff[2];
            end
        end
    end
    // ==================================================
    // pending internal causes; a new event beats the clear
    always_ff @(posedge clock) begin
        if (reset) begin
            pend_ill_ff <= 1'b0;
            pend_pwr_ff <= 1'b0;
            pend_par_ff <= 1'b0;
            pend_av_ff  <= 1'b0;
            pend_iv_ff  <= 1'b0;
        end else begin
            pend_ill_ff <= (pend_ill_ff & ~take_int)
                         | illegal_opcode | aux_ill;
            pend_pwr_ff <= (pend_pwr_ff & ~take_int) | pwr_rise;
            // memory error arrives the state after its cycle
            pend_par_ff <= (pend_par_ff & ~take_int)
                         | (memory_error_flag
                            & sw_ff[SB_PAR_EN]);
            pend_av_ff  <= (pend_av_ff & ~take_int)
                         | ((prot_addr_violation | revoke)
                            & sw_ff[SB_PROT_EN]);
            pend_iv_ff  <= (pend_iv_ff & ~take_int)
                         | (prot_instr_violation
                            & sw_ff[SB_PROT_EN]);
        end
    end
    // ==================================================
    // status word: software write, then hardware updates
    always_comb begin
        nxt_sw = sw_ff;
        // indicators 0-3, 9, 10 are plain software bits
        if (wr && wb_adr_i == OFS_STATUS) begin
            nxt_sw = (sw_ff & ~sw_wmask)
                   | (wb_dat_i[15:0] & sw_wmask);
        end
        // causes set on take; none set means illegal opcode
        if (take_int) begin
            nxt_sw[SB_ADDR_VIO]  = nxt_sw[SB_ADDR_VIO]  | pend_av_ff;
            nxt_sw[SB_INSTR_VIO] = nxt_sw[SB_INSTR_VIO] | pend_iv_ff;
            nxt_sw[SB_PAR_ERR]   = nxt_sw[SB_PAR_ERR]   | pend_par_ff;
            nxt_sw[SB_PWR_FAIL]  = nxt_sw[SB_PWR_FAIL]  | pend_pwr_ff;
            nxt_sw[SB_PROT_EN]   = 1'b0;
            nxt_sw[SB_PAR_EN]    = 1'b0;
        end
        // a take also shuts its own class and every lower class
        nxt_sw[SB_EXP_EN] = nxt_sw[SB_EXP_EN]
                          & ~(take_int | take_exp);
        nxt_sw[SB_DMA_EN] = nxt_sw[SB_DMA_EN]
                          & ~(take_int | take_exp | take_dma);
        nxt_sw[SB_IO_EN]  = nxt_sw[SB_IO_EN] & ~(take_int | take_exp
                          | take_dma | take_io);
    end
    // hardware wins over a same-cycle software write
    always_ff @(posedge clock) begin
        if (reset) begin
            sw_ff <= SW_RESET;
        end else begin
            sw_ff <= nxt_sw;
        end
    end
    // ==================================================
    // vector strobe and address
    always_ff @(posedge clock) begin
        if (reset) begin
            vld_ff <= 1'b0;
            vec_ff <= VEC_INTERNAL;
        end else begin
            vld_ff <= take_int | take_exp | take_dma | take_io;
            if (take_int) begin
                vec_ff <= VEC_INTERNAL;
            end else if (take_exp) begin
                vec_ff <= expanded_vector;
            end else if (take_dma) begin
                vec_ff <= VEC_DMA;
            end else if (take_io) begin
                vec_ff <= VEC_IO;
            end
        end
    end
    // ==================================================
    // aux port: hold execution while the device works
    always_ff @(posedge clock) begin
        if (reset) begin
            aux_ff <= AUX_IDLE;
            rvk_ff <= 1'b0;
        end else begin
            rvk_ff <= revoke;
            unique case (aux_ff)
                AUX_IDLE: begin
                    if (aux_processor_instr && aux_present) begin
                        aux_ff <= AUX_BUSY;
                    end
                end
                AUX_BUSY: begin
                    if (aux_done || revoke) begin
                        aux_ff <= AUX_IDLE;
                    end
                end
            endcase
        end
    end
    // abort request to the aux controller on a live request
    assign aux_abort = (aux_ff == AUX_BUSY)
                     & (int_pend | (expanded_req & sw_ff[SB_EXP_EN])
                        | (dma_channel_req & sw_ff[SB_DMA_EN])
                        | (io_bus_req & sw_ff[SB_IO_EN]));
    assign exec_hold = (aux_ff == AUX_BUSY);
    // ==================================================
    // irq status, set beats write-one-to-clear
    always_ff @(posedge clock) begin
        if (reset) begin
            ists_ff  <= '0;
            imask_ff <= '0;
        end else begin
            if (wr && wb_adr_i == OFS_IRQ_STS && wb_sel_i[0]) begin
                ists_ff <= (ists_ff & ~wb_dat_i[EV_W-1:0]) | ev;
            end else begin
                ists_ff <= ists_ff | ev;
            end
            if (wr && wb_adr_i == OFS_IRQ_MASK && wb_sel_i[0]) begin
                imask_ff <= wb_dat_i[EV_W-1:0];
            end
        end
    end
    // ==================================================
    // wishbone answer, one cycle after the strobe
    always_ff @(posedge clock) begin
        if (reset) begin
            ack_ff  <= 1'b0;
            rdat_ff <= 32'h0;
        end else begin
            ack_ff <= wb_cyc_i & wb_stb_i & ~ack_ff;
            if (rd) begin
                unique case (wb_adr_i)
                    OFS_STATUS:   rdat_ff <= {16'h0, sw_ff};
                    OFS_IRQ_STS:  rdat_ff <= {27'h0, ists_ff};
                    OFS_IRQ_MASK: rdat_ff <= {27'h0, imask_ff};
                    OFS_STATE:    rdat_ff <= {26'h0, exec_hold,
                                    pend_iv_ff, pend_av_ff,
                                    pend_par_ff, pend_pwr_ff,
                                    pend_ill_ff};
                    default:      rdat_ff <= 32'h0;   // unmapped
                endcase
            end
        end
    end
    // outputs
    assign wb_ack_o     = ack_ff;
    assign wb_dat_o     = rdat_ff;
    assign vector_valid = vld_ff;
    assign vector_addr  = vec_ff;
    assign status_word  = sw_ff;
    assign aux_revoke   = rvk_ff;
    assign irq          = |(ists_ff & imask_ff);
    // ==================================================
    // assertions
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    sequence s_take_int;
        check ##0 int_pend;
    endsequence
    sequence s_vec_int;
        vector_valid ##0 (vector_addr == 16'h0000);
    endsequence
    property p_prio;
        not (take_int & (take_exp | take_dma | take_io));
    endproperty
    a_prio: assert property (p_prio)
        else $error("lower class taken with internal pending");
    property p_int_vec;
        s_take_int |=> s_vec_int;
    endproperty
    a_int_vec: assert property (p_int_vec)
        else $error("internal vector not 0000");
    property p_cause;
        (take_int & pend_pwr_ff) |=> status_word[15];
    endproperty
    a_cause: assert property (p_cause)
        else $error("power cause bit not set");
    property p_par_gate;
        (memory_error_flag & ~status_word[11] & ~pend_par_ff)
            |=> ~pend_par_ff;
    endproperty
    a_par_gate: assert property (p_par_gate)
        else $error("parity pending while disabled");
    property p_dma_vec;
        take_dma |=> vector_valid && vector_addr == 16'h0004
                     && !status_word[12] && !status_word[7];
    endproperty
    a_dma_vec: assert property (p_dma_vec)
        else $error("dma take wrong vector or enables");
    property p_io_vec;
        take_io |=> vector_addr == 16'h0006 && !status_word[7];
    endproperty
    a_io_vec: assert property (p_io_vec)
        else $error("io take wrong vector");
    property p_exempt;
        (direct_output_instr | direct_input_instr | exempt_status_instr_a
         | exempt_status_instr_b | rr_to_status_instr) |=> !vector_valid;
    endproperty
    a_exempt: assert property (p_exempt)
        else $error("interrupt taken after exempt instruction");
    property p_hold;
        (aux_processor_instr & aux_present & ~exec_hold)
            |=> exec_hold;
    endproperty
    a_hold: assert property (p_hold)
        else $error("hold not raised for aux instruction");
    property p_revoke;
        revoke |=> aux_revoke && !exec_hold;
    endproperty
    a_revoke: assert property (p_revoke)
        else $error("aux not revoked");
    property p_ack;
        (wb_cyc_i & wb_stb_i & ~wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_ack: assert property (p_ack)
        else $error("bus ack not one cycle");
endmodule : cipc_top

/* File: cipc_pkg.sv */
package cipc_pkg;
    // ==================================================
    // status word layout
    localparam int        SW_W         = 16;
    localparam logic [15:0] SW_RESET   = 16'h0000;
    localparam int        SB_CMP0      = 0;
    localparam int        SB_CMP1      = 1;
    localparam int        SB_OVF       = 2;
    localparam int        SB_CARRY     = 3;
    localparam int        SB_PROT_EN   = 4;
    localparam int        SB_ADDR_VIO  = 5;
    localparam int        SB_INSTR_VIO = 6;
    localparam int        SB_IO_EN     = 7;
    localparam int        SB_EXP_EN    = 8;
    localparam int        SB_BIAS_EN   = 9;
    localparam int        SB_INDEX     = 10;
    localparam int        SB_PAR_EN    = 11;
    localparam int        SB_DMA_EN    = 12;
    localparam int        SB_PAR_ERR   = 14;
    localparam int        SB_PWR_FAIL  = 15;
    // ==================================================
    // fixed vectors
    localparam logic [15:0] VEC_INTERNAL = 16'h0000;
    localparam logic [15:0] VEC_DMA      = 16'h0004;
    localparam logic [15:0] VEC_IO       = 16'h0006;
    // ==================================================
    // wishbone map
    localparam int        ADR_W        = 8;
    localparam logic [7:0] OFS_STATUS   = 8'h00;
    localparam logic [7:0] OFS_IRQ_STS  = 8'h04;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h08;
    localparam logic [7:0] OFS_STATE    = 8'h0c;
    // ==================================================
    // event bits of irq status and mask
    localparam int        EV_W         = 5;
    localparam int        EV_INTERNAL  = 0;
    localparam int        EV_EXPANDED  = 1;
    localparam int        EV_DMA       = 2;
    localparam int        EV_IO        = 3;
    localparam int        EV_REVOKE    = 4;
    // aux port state
    typedef enum logic { AUX_IDLE, AUX_BUSY } cipc_aux_t;
endpackage : cipc_pkg

/* File: cipc_far_model.sv */
`timescale 1ns/1ps
// ==================================================
// far side: expanded system, dma, io bus, memory ctl
module cipc_far_model (
    // system
    input  wire logic        clock,
    input  wire logic        reset,
    // bench commands
    input  wire logic [2:0]  raise,
    input  wire logic [15:0] exp_vec,
    input  wire logic        mem_cycle_end,
    input  wire logic        mem_parity_bad,
    // answers from the block
    input  wire logic        vector_valid,
    input  wire logic [15:0] vector_addr,
    // requests to the block
    output logic             expanded_req,
    output logic [15:0]      expanded_vector,
    output logic             dma_channel_req,
    output logic             io_bus_req,
    output logic             memory_error_flag
);
    import cipc_pkg::*;
    logic [2:0] req_ff;   // expanded, dma, io levels
    logic [2:0] served;   // class whose vector was taken
    logic       memory_error_flag_ff;  // parity flag register
    // a request drops only once its vector is taken
    assign served = {vector_valid && vector_addr == exp_vec,
                     vector_valid && vector_addr == VEC_DMA,
                     vector_valid && vector_addr == VEC_IO};
    // ==================================================
    // request levels
    always_ff @(posedge clock) begin
        if (reset) begin
            req_ff <= 3'h0;
        end else begin
            req_ff <= (req_ff & ~served) | raise;
        end
    end
    // flag in the state after the failing cycle
    always_ff @(posedge clock) begin
        memory_error_flag_ff <= !reset && mem_cycle_end && mem_parity_bad;
    end
    assign {expanded_req, dma_channel_req, io_bus_req} = req_ff;
    // released vector bus shows the inverse, not a stale copy
    assign expanded_vector   = req_ff[2] ? exp_vec : ~exp_vec;
    assign memory_error_flag = memory_error_flag_ff;
endmodule : cipc_far_model

/* File: tb.sv */
`timescale 1ns/1ps
// ==================================================
// self-checking bench for the interrupt block
module tb;
    import cipc_pkg::*;
    logic clock, reset, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o;
    logic [ADR_W-1:0] wb_adr_i;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    logic [3:0] wb_sel_i;
    logic illegal_opcode, power_fail_pin, memory_error_flag;
    logic prot_addr_violation, prot_instr_violation, instr_done;
    logic expanded_req, dma_channel_req, io_bus_req, irq;
    logic direct_output_instr, direct_input_instr, rr_to_status_instr;
    logic exempt_status_instr_a, exempt_status_instr_b, ia;
    logic aux_processor_instr, aux_present, aux_done, aux_abort;
    logic aux_addr_violation, aux_revoke, exec_hold, vector_valid;
    logic [15:0] expanded_vector, vector_addr, status_word;
    logic [2:0] raise;
    logic [15:0] exp_vec;
    logic mem_cycle_end, mem_parity_bad;
    int error_cnt, check_count, cyc_cnt;
    cipc_top dut (.*);
    cipc_far_model far (.*);
    // ==================================================
    // clock and hang guard
    initial clock = 1'b0;
    always #4 clock = ~clock;
    always @(posedge clock) begin
        cyc_cnt++;
        if (cyc_cnt == 5000) begin
            error_cnt++;
            finish_test();
        end
    end
    // ==================================================
    // shared tasks
    task automatic finish_test();
        if (error_cnt == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : finish_test
    task automatic chk(input string nm, input logic [31:0] got, exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %s exp %h got %h", nm, exp, got);
        end
    endtask : chk
    // one classic cycle, held until ack is sampled
    task automatic wb(input logic we, input logic [7:0] a,
                      input logic [31:0] d);
        @(posedge clock);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= 4'hf;
        @(posedge clock);
        while (wb_ack_o !== 1'b1) @(posedge clock);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        #1;
    endtask : wb
    // instruction boundary with exempt flags, ends after take edge
    task automatic step(input logic [4:0] ex);
        @(posedge clock);
        instr_done <= 1'b1;
        {direct_output_instr, direct_input_instr, exempt_status_instr_a,
         exempt_status_instr_b, rr_to_status_instr} <= ex;
        @(posedge clock);
        instr_done <= 1'b0;
        {direct_output_instr, direct_input_instr, exempt_status_instr_a,
         exempt_status_instr_b, rr_to_status_instr} <= 5'h00;
        #1;
    endtask : step
    task automatic take(input logic [15:0] a, st);
        step(5'h00);
        chk("vector_valid", vector_valid, 1);
        chk("vector_addr", vector_addr, a);
        chk("status_word", status_word, st);
    endtask : take
    // ==================================================
    // scenarios
    task automatic t_reset();
        chk("status_rst", status_word, 0);
        wb(1'b0, 8'h40, 0);
        chk("unmapped", rd, 0);
    endtask : t_reset
    task automatic t_priority();
        logic [15:0] va[3] = '{16'h0120, VEC_DMA, VEC_IO};
        logic [15:0] sa[3] = '{16'h0000, 16'h0100, 16'h1100};
        wb(1'b1, OFS_STATUS, 32'h1990);
        @(posedge clock);
        raise <= 3'h7;
        illegal_opcode <= 1'b1;
        @(posedge clock);
        raise <= 3'h0;
        illegal_opcode <= 1'b0;
        take(VEC_INTERNAL, 16'h0000);
        @(posedge clock);
        #1 chk("pulse", vector_valid, 0);
        for (int i = 0; i < 3; i++) begin
            wb(1'b1, OFS_STATUS, 32'h1180);
            take(va[i], sa[i]);
        end
    endtask : t_priority
    task automatic t_skip();
        wb(1'b1, OFS_IRQ_STS, 32'h1f);
        wb(1'b1, OFS_STATUS, 32'h0080);
        @(posedge clock);
        raise <= 3'h1;
        @(posedge clock);
        raise <= 3'h0;
        for (int i = 0; i < 5; i++) begin
            step(5'h01 << i);
            chk("exempt", vector_valid, 0);
        end
        take(VEC_IO, 16'h0000);
        wb(1'b0, OFS_IRQ_STS, 0);
        chk("irq_sts", rd, 32'h08);
        wb(1'b1, OFS_IRQ_MASK, 32'h1f);
        ia = irq;
        wb(1'b1, OFS_IRQ_MASK, 32'h00);
        chk("irq_on", ia, 1);
        chk("irq_mask", irq, 0);
        wb(1'b1, OFS_IRQ_MASK, 32'h1f);
        wb(1'b1, OFS_IRQ_STS, 32'h08);
        chk("irq_clr", irq, 0);
    endtask : t_skip
    task automatic t_aux();
        wb(1'b1, OFS_STATUS, 32'h0010);
        for (int k = 0; k < 2; k++) begin
            @(posedge clock);
            aux_present <= 1'b1;
            aux_processor_instr <= 1'b1;
            @(posedge clock);
            aux_processor_instr <= 1'b0;
            repeat (2) @(posedge clock);
            illegal_opcode <= k[0];
            @(posedge clock);
            illegal_opcode <= 1'b0;
            #1 chk("hold", exec_hold, 1);
            chk("abort", aux_abort, k);
            @(posedge clock);
            {aux_done, aux_addr_violation} <= k ? 2'b01 : 2'b10;
            @(posedge clock);
            {aux_done, aux_addr_violation} <= 2'b00;
            #1 chk("revoke", aux_revoke, k);
            repeat (2) @(posedge clock);
            #1 chk("release", exec_hold, 0);
        end
        take(VEC_INTERNAL, 16'h0020);
        wb(1'b1, OFS_STATUS, 32'h0000);
        @(posedge clock);
        aux_present <= 1'b0;
        aux_processor_instr <= 1'b1;
        @(posedge clock);
        aux_processor_instr <= 1'b0;
        take(VEC_INTERNAL, 16'h0000);
    endtask : t_aux
    task automatic t_cause();
        for (int k = 0; k < 2; k++) begin
            wb(1'b1, OFS_STATUS, k ? 32'h0810 : 32'h0000);
            @(posedge clock);
            {prot_addr_violation, prot_instr_violation} <= 2'b11;
            {mem_cycle_end, mem_parity_bad} <= 2'b11;
            power_fail_pin <= k[0];
            @(posedge clock);
            {prot_addr_violation, prot_instr_violation} <= 2'b00;
            {mem_cycle_end, mem_parity_bad} <= 2'b00;
            repeat (6) @(posedge clock);
            wb(1'b0, OFS_STATE, 0);
            chk("pending", rd, k ? 32'h1e : 32'h0);
            step(5'h00);
            chk("gated", vector_valid, k);
        end
        chk("cause", status_word, 16'hc060);
        step(5'h00);
        chk("sticky", status_word, 16'hc060);
    endtask : t_cause
    // ==================================================
    // main sequence
    initial begin
        {reset, wb_we_i, wb_cyc_i, wb_stb_i, instr_done} = 5'h10;
        {wb_adr_i, wb_dat_i, wb_sel_i, raise, exp_vec} = 0;
        {illegal_opcode, power_fail_pin, prot_addr_violation} = 3'h0;
        {prot_instr_violation, mem_cycle_end, mem_parity_bad} = 3'h0;
        {direct_output_instr, direct_input_instr, rr_to_status_instr} = 0;
        {exempt_status_instr_a, exempt_status_instr_b} = 2'h0;
        {aux_processor_instr, aux_present} = 2'h0;
        {aux_done, aux_addr_violation} = 2'h0;
        exp_vec = 16'h0120;
        repeat (4) @(posedge clock);
        reset <= 1'b0;
        #1;
        t_reset();
        t_priority();
        t_skip();
        t_aux();
        t_cause();
        finish_test();
    end
endmodule : tb
